// >>> bmcr_dac_model.sv
// Purpose: Receiving end of the serial quad DAC
// Assumes: Data sampled on falling clock, load low latches the word
// Notes:   Keeps the last 11 bits shifted in before each load
`timescale 1ns/10ps
module bmcr_dac_model (
  // DAC pins
  input wire dacClk,
  input wire dacData,
  input wire dacLoad
);
  reg   [10:0] shiftWord = 11'h000;
  logic [10:0] words[$];
  // Data changes with the rising clock, so it is taken on the fall
  always @(negedge dacClk)
    shiftWord <= {shiftWord[9:0], dacData};
  always @(negedge dacLoad)
    words.push_back(shiftWord);
endmodule

// >>> bmcr_dac_sched.v
// Purpose: Round-robin scheduler and serial sender for the quad DAC
// Assumes: Pending bits set by register writes, cleared here only
// Notes:   Frame = 2-bit channel, 1 range bit, 8 data bits, MSB first
`timescale 1ns/10ps
`include "bmcr_map.vh"

module bmcr_dac_sched (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Register side
  input  wire        wrStb,
  input  wire [1:0]  wrChan,
  input  wire [31:0] chanData,
  output reg  [3:0]  pending,
  // DAC pins
  output reg         dacClk,
  output reg         dacData,
  output reg         dacLoad
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEND = 3'b010;
  localparam [2:0] ST_LOAD = 3'b100;

  reg [2:0]  state;
  reg [1:0]  nextChan;
  reg [1:0]  curChan;
  reg [10:0] shiftReg;
  reg [3:0]  bitCnt;
  reg        phase;
  reg [3:0]  clearMask;
  reg [1:0]  pick;
  reg        found;
  integer    k;

  // ---------------------------------------------------------------
  // Round-robin pick
  // ---------------------------------------------------------------
  // next pending search
  always @* begin
    pick  = nextChan;
    found = 1'b0;
    for (k = 3; k >= 0; k = k - 1) begin
      if (pending[(nextChan + k[1:0]) & 2'h3]) begin
        pick  = nextChan + k[1:0];
        found = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gPend
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pending[g] <= 1'b0;
        end else if (wrStb && wrChan == g) begin
          pending[g] <= 1'b1;
        end else if (clearMask[g]) begin
          pending[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Sender
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      nextChan  <= 2'h0;
      curChan   <= 2'h0;
      shiftReg  <= 11'h000;
      bitCnt    <= 4'h0;
      phase     <= 1'b0;
      clearMask <= 4'h0;
      dacClk    <= 1'b0;
      dacData   <= 1'b0;
      dacLoad   <= 1'b1;
    end else begin
      clearMask <= 4'h0;
      case (state)
        ST_IDLE: begin
          dacLoad <= 1'b1;
          if (wrStb) begin
            nextChan <= wrChan;
          end else if (found) begin
            curChan  <= pick;
            shiftReg <= {pick, 1'b0, chanData[pick*8 +: 8]};
            bitCnt   <= 4'h0;
            phase    <= 1'b0;
            state    <= ST_SEND;
          end
        end
        ST_SEND: begin
          phase <= ~phase;
          if (!phase) begin
            dacData  <= shiftReg[10];
            dacClk   <= 1'b1;
          end else begin
            dacClk   <= 1'b0;
            shiftReg <= {shiftReg[9:0], 1'b0};
            bitCnt   <= bitCnt + 4'h1;
            if (bitCnt == `BMCR_DAC_FRAME_BITS - 1) begin
              state <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          dacLoad            <= 1'b0;
          clearMask[curChan] <= 1'b1;
          nextChan           <= curChan + 2'h1;
          state              <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> bmcr_map.vh
// Purpose: Offsets, fields, reset values and counts of the misc control bank
// Assumes: 16-bit parallel host bus, word index offsets
// Notes:   Included by bmcr_top.v and bmcr_dac_sched.v
//
// Behaviour
// - Write to DAC channel schedules its update
// - Serve pending channels round-robin from written one
// - DAC channel values reset to zero
// - Pending field shows unsent written channels
// - Protocol bit: 1 differential, 0 multidrop
// - Mux select drives outputs, resets zero
// - Mux codes: sensors, rails, test, unconnected
// - Diagnostic register returns fourteen live inputs
// - Scratch word stores and returns host data
// - Lamp force bits light LEDs, else status
// - Force enable drives interrupt and ready pins
// - Capture address on every strobed write
// - Polarity bit 1 makes error input active-low
// - Timer counts to period then wraps zero
// - Pulse enable drives spare pin zero
`ifndef BMCR_MAP_VH
`define BMCR_MAP_VH

`define BMCR_ADDR_DAC0      8'h1D
`define BMCR_ADDR_DAC3      8'h20
`define BMCR_ADDR_PENDING   8'h21
`define BMCR_ADDR_PROTOCOL  8'h22
`define BMCR_ADDR_AMUX      8'h23
`define BMCR_ADDR_RAWIN     8'h24
`define BMCR_ADDR_SCRATCH   8'h25
`define BMCR_ADDR_LAMP      8'h26
`define BMCR_ADDR_IRQFORCE  8'h27
`define BMCR_ADDR_WRADDR    8'h28
`define BMCR_ADDR_POLARITY  8'h29
`define BMCR_ADDR_PULSE     8'h2A

`define BMCR_DAC_RESET      8'h00
`define BMCR_ZERO16         16'h0000
`define BMCR_IRQF_EN_BIT    5
`define BMCR_PULSE_EN_BIT   15

// 8 data bits per DAC frame plus framing, 2 cycles per bit
`define BMCR_DAC_FRAME_BITS 11
`define BMCR_DAC_BIT_CYC    2

`endif

// >>> bmcr_top.v
// Purpose: Host-visible misc control and diagnostic register bank
// Assumes: Host strobes synchronous to sys_clk, active-low chip select
// Notes:   Registers answer at word offsets 0x1D to 0x2A
`timescale 1ns/10ps
`include "bmcr_map.vh"

module bmcr_top (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Host bus
  input  wire        hostCs_n,
  input  wire        hostWr_n,
  input  wire        hostRd_n,
  input  wire [7:0]  hostAddr,
  input  wire [15:0] hostWdata,
  output reg  [15:0] hostRdata,
  output reg         hostDataOe,
  // Diagnostic inputs
  input  wire [13:0] rawInputs,
  input  wire [8:0]  moduleErrIn,
  input  wire [3:0]  intStatusLamp,
  input  wire [4:0]  normalIrqPins,
  input  wire        spareOut0,
  input  wire        spareDir0,
  // Outputs
  output reg         serialProtocol,
  output reg  [3:0]  analogMuxSel,
  output reg  [3:0]  lampOut,
  output reg  [4:0]  irqPinOut,
  output reg  [8:0]  faultActive,
  output reg         spare0Out,
  output reg         spare0Oe,
  // DAC pins
  output wire        dacClk,
  output wire        dacData,
  output wire        dacLoad
);

  reg  [31:0] dacValue;
  reg  [15:0] scratchWord;
  reg  [3:0]  lampOverride;
  reg  [5:0]  irqOverride;
  reg  [7:0]  wrAddrCapture;
  reg  [8:0]  faultPolarity;
  reg  [14:0] pulsePeriod;
  reg         pulseEnable;
  reg  [14:0] pulseTimer;
  reg         pulseOut;
  reg  [15:0] next_rdata;
  wire [3:0]  pending;
  wire        wrStb;
  wire        rdStb;
  wire        dacHit;
  wire [1:0]  dacIdx;

  assign wrStb  = !hostCs_n && !hostWr_n;
  assign rdStb  = !hostCs_n && !hostRd_n;
  assign dacHit = wrStb && hostAddr >= `BMCR_ADDR_DAC0 &&
                  hostAddr <= `BMCR_ADDR_DAC3;
  assign dacIdx = hostAddr[1:0] - 2'h1;

  // ---------------------------------------------------------------
  // DAC scheduler
  // ---------------------------------------------------------------
  // write schedules update
  bmcr_dac_sched uSched (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wrStb    (dacHit),
    .wrChan   (dacIdx),
    .chanData (dacValue),
    .pending  (pending),
    .dacClk   (dacClk),
    .dacData  (dacData),
    .dacLoad  (dacLoad)
  );

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dacValue       <= 32'h00000000;
      serialProtocol <= 1'b0;
      analogMuxSel   <= 4'h0;
      scratchWord    <= `BMCR_ZERO16;
      lampOverride   <= 4'h0;
      irqOverride    <= 6'h00;
      wrAddrCapture  <= 8'h00;
      faultPolarity  <= 9'h000;
      pulsePeriod    <= 15'h0000;
      pulseEnable    <= 1'b0;
    end else if (wrStb) begin
      wrAddrCapture <= hostAddr;
      if (dacHit) begin
        dacValue[dacIdx*8 +: 8] <= hostWdata[7:0];
      end else if (hostAddr == `BMCR_ADDR_PROTOCOL) begin
        serialProtocol <= hostWdata[0];
      end else if (hostAddr == `BMCR_ADDR_AMUX) begin
        analogMuxSel <= hostWdata[3:0];
      end else if (hostAddr == `BMCR_ADDR_SCRATCH) begin
        scratchWord <= hostWdata;
      end else if (hostAddr == `BMCR_ADDR_LAMP) begin
        lampOverride <= hostWdata[3:0];
      end else if (hostAddr == `BMCR_ADDR_IRQFORCE) begin
        irqOverride <= hostWdata[5:0];
      end else if (hostAddr == `BMCR_ADDR_POLARITY) begin
        faultPolarity <= hostWdata[8:0];
      end else if (hostAddr == `BMCR_ADDR_PULSE) begin
        pulsePeriod <= hostWdata[14:0];
        pulseEnable <= hostWdata[`BMCR_PULSE_EN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always @* begin
    next_rdata = `BMCR_ZERO16;
    if (hostAddr >= `BMCR_ADDR_DAC0 && hostAddr <= `BMCR_ADDR_DAC3) begin
      next_rdata = {8'h00, dacValue[dacIdx*8 +: 8]};
    end else if (hostAddr == `BMCR_ADDR_PENDING) begin
      next_rdata = {12'h000, pending};
    end else if (hostAddr == `BMCR_ADDR_PROTOCOL) begin
      next_rdata = {15'h0000, serialProtocol};
    end else if (hostAddr == `BMCR_ADDR_AMUX) begin
      next_rdata = {12'h000, analogMuxSel};
    end else if (hostAddr == `BMCR_ADDR_RAWIN) begin
      next_rdata = {2'h0, rawInputs};
    end else if (hostAddr == `BMCR_ADDR_SCRATCH) begin
      next_rdata = scratchWord;
    end else if (hostAddr == `BMCR_ADDR_LAMP) begin
      next_rdata = {12'h000, lampOverride};
    end else if (hostAddr == `BMCR_ADDR_IRQFORCE) begin
      next_rdata = {10'h000, irqOverride};
    end else if (hostAddr == `BMCR_ADDR_WRADDR) begin
      next_rdata = {8'h00, wrAddrCapture};
    end else if (hostAddr == `BMCR_ADDR_POLARITY) begin
      next_rdata = {7'h00, faultPolarity};
    end else if (hostAddr == `BMCR_ADDR_PULSE) begin
      next_rdata = {pulseEnable, pulsePeriod};
    end
  end

  // ---------------------------------------------------------------
  // Pulse timer and pin outputs
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulseTimer  <= 15'h0000;
      pulseOut    <= 1'b0;
      hostRdata   <= `BMCR_ZERO16;
      hostDataOe  <= 1'b0;
      lampOut     <= 4'h0;
      irqPinOut   <= 5'h00;
      faultActive <= 9'h000;
      spare0Out   <= 1'b0;
      spare0Oe    <= 1'b0;
    end else begin
      hostRdata  <= next_rdata;
      hostDataOe <= rdStb;
      if (pulseTimer >= pulsePeriod) begin
        pulseTimer <= 15'h0000;
        pulseOut   <= 1'b1;
      end else begin
        pulseTimer <= pulseTimer + 15'h0001;
        pulseOut   <= 1'b0;
      end
      lampOut <= lampOverride | intStatusLamp;
      irqPinOut <= irqOverride[`BMCR_IRQF_EN_BIT] ? irqOverride[4:0]
                                                  : normalIrqPins;
      faultActive <= moduleErrIn ^ faultPolarity;
      if (pulseEnable) begin
        spare0Out <= pulseOut;
        spare0Oe  <= 1'b1;
      end else begin
        spare0Out <= spareOut0;
        spare0Oe  <= spareDir0;
      end
    end
  end

endmodule

// >>> bmcr_top_monitor.sv
// Purpose: Port-level checks for the misc control bank
// Assumes: Registered outputs settle within two cycles of a write
// Notes:   A write window is one write followed by two idle cycles, or by one idle cycle for the protocol bit
`timescale 1ns/10ps
module bmcr_monitor (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst,
  // Host bus
  input wire        hostCs_n,
  input wire        hostWr_n,
  input wire        hostRd_n,
  input wire [7:0]  hostAddr,
  input wire [15:0] hostWdata,
  input wire [15:0] hostRdata,
  // Pins
  input wire [13:0] rawInputs,
  input wire [8:0]  moduleErrIn,
  input wire        serialProtocol,
  input wire [3:0]  analogMuxSel,
  input wire [3:0]  lampOut,
  input wire [4:0]  irqPinOut,
  input wire [8:0]  faultActive,
  input wire        dacLoad
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire wr = !hostCs_n && !hostWr_n;

  a_mux_follows: assert property (
    (wr && hostAddr == 8'h23) ##1 !wr [*2]
    |-> analogMuxSel == $past(hostWdata[3:0], 2)) else $error("mux stale");
  a_protocol_bit: assert property (
    (wr && hostAddr == 8'h22) ##1 !wr
    |=> serialProtocol == $past(hostWdata[0], 2)) else $error("mode stale");
  a_irq_forced: assert property (
    (wr && hostAddr == 8'h27 && hostWdata[5]) ##1 !wr [*2]
    |-> irqPinOut == $past(hostWdata[4:0], 2)) else $error("irq not forced");
  a_lamp_forced: assert property (
    (wr && hostAddr == 8'h26) ##1 !wr [*2] |-> (lampOut
    | ~$past(hostWdata[3:0], 2)) == 4'hF) else $error("lamp not lit");
  a_fault_polarity: assert property (
    (wr && hostAddr == 8'h29) ##1 !wr [*2] |-> faultActive ==
    ($past(moduleErrIn) ^ $past(hostWdata[8:0], 2))) else $error("polarity");
  a_raw_view: assert property (
    (!hostCs_n && !hostRd_n && hostAddr == 8'h24)
    |=> hostRdata == {2'h0, $past(rawInputs)}) else $error("raw view");
  a_load_pulse: assert property (
    $fell(dacLoad) |=> dacLoad) else $error("load not one cycle");
  a_dac_update: assert property (
    (wr && hostAddr >= 8'h1D && hostAddr <= 8'h20)
    |-> ##[1:100] $fell(dacLoad)) else $error("no dac load");
endmodule

bind bmcr_top bmcr_monitor i_mon (.sys_clk(sys_clk), .rst(rst),
  .hostCs_n(hostCs_n), .hostWr_n(hostWr_n), .hostRd_n(hostRd_n),
  .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata),
  .rawInputs(rawInputs), .moduleErrIn(moduleErrIn),
  .serialProtocol(serialProtocol), .analogMuxSel(analogMuxSel),
  .lampOut(lampOut), .irqPinOut(irqPinOut), .faultActive(faultActive),
  .dacLoad(dacLoad));

// >>> bmcr_top_tb.sv
// Purpose: Self-checking bench for the misc control bank
// Assumes: Inputs change on the falling edge of sys_clk
// Notes:   DAC words are {channel, range, data}
`timescale 1ns/10ps
module bmcr_top_tb;
  reg         sys_clk = 0, rst, hostCs_n, hostWr_n, hostRd_n;
  reg  [7:0]  hostAddr;
  reg  [15:0] hostWdata, rd, cnt;
  reg  [13:0] rawInputs;
  reg  [8:0]  moduleErrIn;
  reg  [3:0]  intStatusLamp;
  reg  [4:0]  normalIrqPins;
  reg         spareOut0, spareDir0;
  wire [15:0] hostRdata;
  wire [3:0]  analogMuxSel, lampOut;
  wire [4:0]  irqPinOut;
  wire [8:0]  faultActive;
  wire        serialProtocol, spare0Out, spare0Oe, dacClk, dacData, dacLoad;
  wire        hostDataOe;
  integer     mismatches = 0, n_tests = 0, cyc = 0, i;

  bmcr_top i_dut (.sys_clk(sys_clk), .rst(rst), .hostCs_n(hostCs_n),
    .hostWr_n(hostWr_n), .hostRd_n(hostRd_n), .hostAddr(hostAddr),
    .hostWdata(hostWdata), .hostRdata(hostRdata), .hostDataOe(hostDataOe),
    .rawInputs(rawInputs), .moduleErrIn(moduleErrIn),
    .intStatusLamp(intStatusLamp), .normalIrqPins(normalIrqPins),
    .spareOut0(spareOut0), .spareDir0(spareDir0),
    .serialProtocol(serialProtocol), .analogMuxSel(analogMuxSel),
    .lampOut(lampOut), .irqPinOut(irqPinOut), .faultActive(faultActive),
    .spare0Out(spare0Out), .spare0Oe(spare0Oe), .dacClk(dacClk),
    .dacData(dacData), .dacLoad(dacLoad));
  bmcr_dac_model i_dac (.dacClk(dacClk), .dacData(dacData),
    .dacLoad(dacLoad));

  always #50 sys_clk = ~sys_clk;

  task wr(input [7:0] a, input [15:0] d);
    @(negedge sys_clk);
    hostAddr = a;
    hostWdata = d;
    {hostCs_n, hostWr_n} = 2'b00;
    @(negedge sys_clk);
    {hostCs_n, hostWr_n} = 2'b11;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rchk(input [7:0] a, input [15:0] exp);
    @(negedge sys_clk);
    hostAddr = a;
    {hostCs_n, hostRd_n} = 2'b00;
    @(negedge sys_clk);
    rd = hostRdata;
    chk({15'h0000, hostDataOe}, 16'h0001);
    {hostCs_n, hostRd_n} = 2'b11;
    chk(rd, exp);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      final_report;
    end
  end

  initial begin
    {rst, hostCs_n, hostWr_n, hostRd_n} = 4'hF;
    {hostAddr, hostWdata} = 24'h000000;
    {rawInputs, moduleErrIn} = {14'h2A5C, 9'h0F0};
    {intStatusLamp, normalIrqPins} = {4'h0, 5'h0A};
    {spareOut0, spareDir0} = 2'b00;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    for (i = 8'h1D; i <= 8'h2A; i = i + 1)
      if (i != 8'h24 && i != 8'h28) rchk(i[7:0], 16'h0000);
    $display("test reset done");
    wr(8'h25, 16'hA5C3);
    rchk(8'h25, 16'hA5C3);
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'h23, i[15:0]);
      rchk(8'h23, i[15:0]);
      chk({12'h000, analogMuxSel}, i[15:0]);
    end
    for (i = 1; i >= 0; i = i - 1) begin
      wr(8'h22, i[15:0]);
      rchk(8'h22, i[15:0]);
      chk({15'h0000, serialProtocol}, i[15:0]);
    end
    rchk(8'h24, 16'h2A5C);
    wr(8'h3F, 16'hFFFF);
    rchk(8'h28, 16'h003F);
    wr(8'h24, 16'h1234);
    rchk(8'h28, 16'h0024);
    rchk(8'h24, 16'h2A5C);
    $display("test registers done");
    wr(8'h26, 16'h0005);
    @(negedge sys_clk);
    chk({12'h000, lampOut}, 16'h0005);
    intStatusLamp = 4'hA;
    wr(8'h26, 16'h0000);
    rchk(8'h26, 16'h0000);
    chk({12'h000, lampOut}, 16'h000A);
    wr(8'h27, 16'h0015);
    rchk(8'h27, 16'h0015);
    chk({11'h000, irqPinOut}, 16'h000A);
    wr(8'h27, 16'h0035);
    rchk(8'h27, 16'h0035);
    chk({11'h000, irqPinOut}, 16'h0015);
    wr(8'h29, 16'h00FF);
    rchk(8'h29, 16'h00FF);
    chk({7'h00, faultActive}, 16'h000F);
    $display("test pins done");
    wr(8'h1F, 16'h0012);
    wr(8'h1D, 16'h0034);
    wr(8'h20, 16'h0056);
    rchk(8'h21, 16'h000D);
    for (i = 0; i < 300 && i_dac.words.size() < 3; i = i + 1)
      @(negedge sys_clk);
    rchk(8'h21, 16'h0000);
    chk(i_dac.words.size(), 16'h0003);
    chk({5'h00, i_dac.words[0]}, 16'h0412);
    chk({5'h00, i_dac.words[1]}, 16'h0656);
    chk({5'h00, i_dac.words[2]}, 16'h0034);
    rchk(8'h1F, 16'h0012);
    $display("test dac done");
    wr(8'h2A, 16'h8003);
    rchk(8'h2A, 16'h8003);
    cnt = 16'h0000;
    repeat (40) begin
      @(negedge sys_clk);
      cnt = cnt + spare0Out;
    end
    chk(cnt, 16'h000A);
    chk({15'h0000, spare0Oe}, 16'h0001);
    wr(8'h2A, 16'h0003);
    spareOut0 = 1;
    repeat (3) @(negedge sys_clk);
    chk({14'h0000, spare0Oe, spare0Out}, 16'h0001);
    $display("test pulse done");
    final_report;
  end
endmodule
